// [rtl/window_cfg_pkg.sv]
// Constants for the configuration-space window register bank
// How it works
// - Bit 0 of each base register except a 64-bit upper half is read-only: 0 memory, 1 I/O.
// - Memory base bits 2:1 read 00b for 32-bit, 10b for 64-bit decoders.
// - Memory base bit 3 reads zero: windows are non-prefetchable.
// - Register window is 128 KB; bits 16:4 zero, bits 31:17 and upper writable.
// - Flash base zero bits follow flash size: 15:4, 16:4 or 18:4.
// - I/O window is 8 bytes; bit 2 zero, higher bits writable.
// - Boot ROM bit 0 is a writable enable, reset zero, gating ROM access.
// - Boot ROM bits 10:1 read zero; writes to them are stored but masked on read.
// - Boot ROM address bits 31:11; zero bits 15:11 up to 18:11 by flash size.
// - Card info pointer reads 22h when clock-run and narrow options set, else 0.
// - Pointer bits 2:0 select space: 0 config, 1-6 base registers, 7 ROM.
// - Pointer bits 31:3 read-only offset in 8-byte units, 4 when enabled.
// - Conventional mode with narrow option uses 32-bit bases, else 64-bit pairs.
package window_cfg_pkg;
    // Configuration space byte offsets
    localparam logic [7:0] OFS_BASE0 = 8'h10;
    localparam logic [7:0] OFS_BASE1 = 8'h14;
    localparam logic [7:0] OFS_BASE2 = 8'h18;
    localparam logic [7:0] OFS_BASE3 = 8'h1C;
    localparam logic [7:0] OFS_BASE4 = 8'h20;
    localparam logic [7:0] OFS_BASE5 = 8'h24;
    localparam logic [7:0] OFS_CARD_INFO = 8'h28;
    localparam logic [7:0] OFS_BOOT_ROM = 8'h30;
    // Flash size codes
    localparam logic [1:0] FLASH_64K = 2'h0;
    localparam logic [1:0] FLASH_128K = 2'h1;
    localparam logic [1:0] FLASH_256K = 2'h2;
    localparam logic [1:0] FLASH_512K = 2'h3;
    // Writable address masks
    localparam logic [31:0] MASK_REG = 32'hFFFE_0000;
    localparam logic [31:0] MASK_FL64 = 32'hFFFF_0000;
    localparam logic [31:0] MASK_FL128 = 32'hFFFE_0000;
    localparam logic [31:0] MASK_FL256 = 32'hFFF8_0000;
    localparam logic [31:0] MASK_IO = 32'hFFFF_FFF8;
    localparam logic [31:0] MASK_ROM64 = 32'hFFFF_0000;
    localparam logic [31:0] MASK_ROM128 = 32'hFFFE_0000;
    localparam logic [31:0] MASK_ROM256 = 32'hFFFC_0000;
    localparam logic [31:0] MASK_ROM512 = 32'hFFF8_0000;
    // Attribute bits
    localparam logic [3:0] ATTR_MEM32 = 4'h0;
    localparam logic [3:0] ATTR_MEM64 = 4'h4;
    localparam logic [1:0] ATTR_IO = 2'h1;
    localparam int ROM_EN_BIT = 0;
    // Card info pointer values
    localparam logic [31:0] CARD_INFO_ON = 32'h0000_0022;
    localparam logic [31:0] CARD_INFO_OFF = 32'h0000_0000;
    // Reset values
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
endpackage : window_cfg_pkg

// [rtl/window_cfg_regs.sv]
// Base address, boot ROM and card info registers in configuration space
`timescale 1ns/10ps
module window_cfg_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Configuration access
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // Loader options and mode
    input wire logic [1:0] flash_size,
    input wire logic narrow_base_option,
    input wire logic clock_run_option,
    input wire logic extended_bus_mode,
    // Decode results
    output logic [63:0] reg_base,
    output logic [63:0] flash_base,
    output logic [31:0] io_base,
    output logic [31:0] rom_base,
    output logic rom_enable,
    output logic wide_mode
);
    logic [63:0] reg_base_q;
    logic [63:0] flash_base_q;
    logic [31:0] io_base_q;
    logic [31:0] rom_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    wire logic wide = extended_bus_mode | ~narrow_base_option;
    wire logic [3:0] mem_attr = wide ? window_cfg_pkg::ATTR_MEM64
                                     : window_cfg_pkg::ATTR_MEM32;

    function automatic logic [31:0] flash_mask(input logic [1:0] sz);
        case (sz)
            window_cfg_pkg::FLASH_64K: flash_mask = window_cfg_pkg::MASK_FL64;
            window_cfg_pkg::FLASH_128K: flash_mask = window_cfg_pkg::MASK_FL128;
            default: flash_mask = window_cfg_pkg::MASK_FL256;
        endcase
    endfunction : flash_mask

    function automatic logic [31:0] rom_mask(input logic [1:0] sz);
        case (sz)
            window_cfg_pkg::FLASH_64K: rom_mask = window_cfg_pkg::MASK_ROM64;
            window_cfg_pkg::FLASH_128K: rom_mask = window_cfg_pkg::MASK_ROM128;
            window_cfg_pkg::FLASH_256K: rom_mask = window_cfg_pkg::MASK_ROM256;
            default: rom_mask = window_cfg_pkg::MASK_ROM512;
        endcase
    endfunction : rom_mask

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // Window address decode; flash and I/O placement depends on mode
    wire logic [7:0] ofs_flash_lo = wide ? window_cfg_pkg::OFS_BASE2 : window_cfg_pkg::OFS_BASE1;
    wire logic [7:0] ofs_io = wide ? window_cfg_pkg::OFS_BASE4 : window_cfg_pkg::OFS_BASE2;
    wire logic hit_reg_lo = cfg_addr == window_cfg_pkg::OFS_BASE0;
    wire logic hit_reg_hi = wide && cfg_addr == window_cfg_pkg::OFS_BASE1;
    wire logic hit_fl_lo = cfg_addr == ofs_flash_lo;
    wire logic hit_fl_hi = wide && cfg_addr == window_cfg_pkg::OFS_BASE3;
    wire logic hit_io = cfg_addr == ofs_io;
    wire logic hit_rom = cfg_addr == window_cfg_pkg::OFS_BOOT_ROM;
    wire logic hit_card = cfg_addr == window_cfg_pkg::OFS_CARD_INFO;

    wire logic [31:0] fmask = flash_mask(flash_size);
    wire logic [31:0] rmask = rom_mask(flash_size);
    wire logic [31:0] rom_wmask = rmask | 32'h0000_0001;

    // Reads recompute masks so a flash size change never exposes stale low bits
    wire logic [31:0] reg_lo_rd = (reg_base_q[31:0] & window_cfg_pkg::MASK_REG)
                                  | {28'h000_0000, mem_attr};
    wire logic [31:0] fl_lo_rd = (flash_base_q[31:0] & fmask) | {28'h000_0000, mem_attr};
    wire logic [31:0] io_rd = (io_base_q & window_cfg_pkg::MASK_IO)
                              | {30'h0000_0000, window_cfg_pkg::ATTR_IO};
    wire logic [31:0] rom_rd = rom_q & rom_wmask;
    wire logic [31:0] card_rd = (clock_run_option && narrow_base_option)
                                ? window_cfg_pkg::CARD_INFO_ON
                                : window_cfg_pkg::CARD_INFO_OFF;

    always_comb begin
        if (hit_reg_lo) begin
            rdata_d = reg_lo_rd;
        end else if (hit_reg_hi) begin
            rdata_d = reg_base_q[63:32];
        end else if (hit_fl_lo) begin
            rdata_d = fl_lo_rd;
        end else if (hit_fl_hi) begin
            rdata_d = flash_base_q[63:32];
        end else if (hit_io) begin
            rdata_d = io_rd;
        end else if (hit_rom) begin
            rdata_d = rom_rd;
        end else if (hit_card) begin
            rdata_d = card_rd;
        end else begin
            rdata_d = 32'h0000_0000;
        end
    end

    // Write strobes, one per stored word
    wire logic wr_reg_lo = cfg_wr && hit_reg_lo;
    wire logic wr_reg_hi = cfg_wr && hit_reg_hi;
    wire logic wr_fl_lo = cfg_wr && hit_fl_lo;
    wire logic wr_fl_hi = cfg_wr && hit_fl_hi;
    wire logic wr_io = cfg_wr && hit_io;
    wire logic wr_rom = cfg_wr && hit_rom;

    // Next values after byte-lane merge
    wire logic [31:0] reg_lo_d = merge(reg_base_q[31:0], cfg_wdata, cfg_be)
                                 & window_cfg_pkg::MASK_REG;
    wire logic [31:0] reg_hi_d = merge(reg_base_q[63:32], cfg_wdata, cfg_be);
    wire logic [31:0] fl_lo_d = merge(flash_base_q[31:0], cfg_wdata, cfg_be);
    wire logic [31:0] fl_hi_d = merge(flash_base_q[63:32], cfg_wdata, cfg_be);
    wire logic [31:0] io_d = merge(io_base_q, cfg_wdata, cfg_be)
                             & window_cfg_pkg::MASK_IO;
    // Boot ROM word kept whole; size can change after programming
    wire logic [31:0] rom_d = merge(rom_q, cfg_wdata, cfg_be);

    // Register window base, both halves
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_base_q <= {window_cfg_pkg::BASE_RESET, window_cfg_pkg::BASE_RESET};
        end else begin
            if (wr_reg_lo) begin
                reg_base_q[31:0] <= reg_lo_d;
            end
            if (wr_reg_hi) begin
                reg_base_q[63:32] <= reg_hi_d;
            end
        end
    end

    // Flash window base, both halves
    always_ff @(posedge clock) begin
        if (reset) begin
            flash_base_q <= {window_cfg_pkg::BASE_RESET, window_cfg_pkg::BASE_RESET};
        end else begin
            if (wr_fl_lo) begin
                flash_base_q[31:0] <= fl_lo_d;
            end
            if (wr_fl_hi) begin
                flash_base_q[63:32] <= fl_hi_d;
            end
        end
    end

    // I/O window base
    always_ff @(posedge clock) begin
        if (reset) begin
            io_base_q <= window_cfg_pkg::BASE_RESET;
        end else if (wr_io) begin
            io_base_q <= io_d;
        end
    end

    // Boot ROM base and enable
    always_ff @(posedge clock) begin
        if (reset) begin
            rom_q <= window_cfg_pkg::BASE_RESET;
        end else if (wr_rom) begin
            rom_q <= rom_d;
        end
    end

    // Read data, one cycle behind the address
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign cfg_rdata = rdata_q;
    // Upper halves count only in 64-bit form
    assign reg_base = {wide ? reg_base_q[63:32] : 32'h0000_0000, reg_lo_rd & 32'hFFFF_FFF0};
    assign flash_base = {wide ? flash_base_q[63:32] : 32'h0000_0000, fl_lo_rd & 32'hFFFF_FFF0};
    assign io_base = io_rd & window_cfg_pkg::MASK_IO;
    assign rom_base = rom_rd & rmask;
    assign rom_enable = rom_q[window_cfg_pkg::ROM_EN_BIT];
    assign wide_mode = wide;
endmodule : window_cfg_regs

// [tb/window_cfg_regs_properties.sv]
// Port checker for the configuration window registers
`timescale 1ns/10ps
module window_cfg_regs_properties (
    // Clock, reset and access
    input logic clock,
    input logic reset,
    input logic cfg_wr,
    input logic [7:0] cfg_addr,
    input logic [3:0] cfg_be,
    input logic [31:0] cfg_wdata,
    input logic [31:0] cfg_rdata,
    // Options and decode
    input logic [1:0] flash_size,
    input logic narrow_base_option,
    input logic clock_run_option,
    input logic extended_bus_mode,
    input logic [31:0] io_base,
    input logic [31:0] rom_base,
    input logic rom_enable,
    input logic wide_mode
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    a_io_attr: assert property (wide_mode && cfg_addr == 8'h20 |=> cfg_rdata[2:0] == 3'h1)
        else $error("I/O base attribute bits wrong");
    a_reg_attr: assert property (cfg_addr == 8'h10 |=> cfg_rdata[16:0] ==
        ($past(wide_mode) ? 17'h0_0004 : 17'h0_0000)) else $error("Register base low bits wrong");
    a_flash_low: assert property (!wide_mode && cfg_addr == 8'h14 && flash_size == 2'h0
        |=> cfg_rdata[15:0] == 16'h0000) else $error("Flash base low bits wrong");
    a_rom_low: assert property (cfg_addr == 8'h30 && !cfg_wr
        |=> cfg_rdata[10:0] == {10'h000, rom_enable}) else $error("Boot ROM low bits wrong");
    a_rom_en_write: assert property (cfg_wr && cfg_addr == 8'h30 && cfg_be[0]
        |=> rom_enable == $past(cfg_wdata[0])) else $error("Boot ROM enable not written");
    a_rom_size: assert property (flash_size == 2'h3 |-> rom_base[18:0] == 19'h0_0000)
        else $error("Boot ROM size mask wrong");
    a_card_value: assert property (cfg_addr == 8'h28 |=> cfg_rdata ==
        ($past(narrow_base_option && clock_run_option) ? 32'h0000_0022 : 32'h0000_0000))
        else $error("Card info pointer wrong");
    a_io_zero: assert property (io_base[2:0] == 3'h0)
        else $error("I/O base low bits set");
    a_wide_select: assert property (wide_mode == (extended_bus_mode || !narrow_base_option))
        else $error("Wide mode selection wrong");
    c_rom_on: cover property (rom_enable && cfg_addr == 8'h30);
    c_card_on: cover property (narrow_base_option && clock_run_option && cfg_addr == 8'h28);
    c_narrow_io: cover property (!wide_mode && cfg_addr == 8'h18);
endmodule : window_cfg_regs_properties
bind window_cfg_regs window_cfg_regs_properties u_window_cfg_regs_properties (
    .clock(clock), .reset(reset), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .flash_size(flash_size),
    .narrow_base_option(narrow_base_option), .clock_run_option(clock_run_option),
    .extended_bus_mode(extended_bus_mode), .io_base(io_base), .rom_base(rom_base),
    .rom_enable(rom_enable), .wide_mode(wide_mode));

// [tb/cfg_host_model.sv]
// Host bridge model issuing configuration cycles
`timescale 1ns/10ps
module cfg_host_model (
    // Configuration access
    input logic clock,
    output logic cfg_wr = 1'b0,
    output logic [7:0] cfg_addr = 8'h00,
    output logic [3:0] cfg_be = 4'h0,
    output logic [31:0] cfg_wdata = 32'h0000_0000,
    input logic [31:0] cfg_rdata
);
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clock);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_wr <= 1'b0;
        // Released data inverted so a stale value cannot pass
        cfg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        cfg_addr <= a;
        @(posedge clock);
        #1 d = cfg_rdata;
    endtask : rd
endmodule : cfg_host_model

// [tb/pci_bar_rom_cis_config_bench.sv]
// Self-checking bench for the configuration window registers
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module pci_bar_rom_cis_config_bench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [1:0] flash_size = 2'h0;
    logic narrow_base_option = 1'b0;
    logic clock_run_option = 1'b0;
    logic extended_bus_mode = 1'b0;
    logic cfg_wr;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, io_base, rom_base;
    logic [63:0] reg_base, flash_base;
    logic rom_enable, wide_mode;
    logic [31:0] fl [3] = '{32'hFFFF_0004, 32'hFFFE_0004, 32'hFFF8_0004};
    logic [31:0] rm [4] = '{32'hFFFF_0001, 32'hFFFE_0001, 32'hFFFC_0001, 32'hFFF8_0001};
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    window_cfg_regs u_window_cfg_regs (.clock(clock), .reset(reset), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .flash_size(flash_size), .narrow_base_option(narrow_base_option),
        .clock_run_option(clock_run_option), .extended_bus_mode(extended_bus_mode),
        .reg_base(reg_base), .flash_base(flash_base), .io_base(io_base), .rom_base(rom_base),
        .rom_enable(rom_enable), .wide_mode(wide_mode));
    cfg_host_model u_cfg_host_model (.clock(clock), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
    always #2.5 clock = ~clock;
    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clock) begin
        cycles++;
        if (cycles > 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        u_cfg_host_model.rd(a, v);
        `CHK(v, e)
    endtask : chk_rd
    task automatic t_wide_sizing;
        chk_rd(8'h10, 32'h0000_0004);
        chk_rd(8'h20, 32'h0000_0001);
        for (int i = 0; i < 6; i++) u_cfg_host_model.wr(8'(16 + 4 * i), '1, 4'hF);
        chk_rd(8'h10, 32'hFFFE_0004);
        chk_rd(8'h14, 32'hFFFF_FFFF);
        chk_rd(8'h20, 32'hFFFF_FFF9);
        chk_rd(8'h24, 32'h0000_0000);
        chk_rd(8'h28, 32'h0000_0000);
        for (int f = 0; f < 3; f++) begin
            @(posedge clock) flash_size <= 2'(f);
            chk_rd(8'h18, fl[f]);
        end
        `CHK(reg_base, 64'hFFFF_FFFF_FFFE_0000)
        `CHK(flash_base, 64'hFFFF_FFFF_FFF8_0000)
        `CHK(io_base, 32'hFFFF_FFF8)
    endtask : t_wide_sizing
    task automatic t_narrow_map;
        @(posedge clock) narrow_base_option <= 1'b1;
        clock_run_option <= 1'b1;
        flash_size <= 2'h0;
        for (int i = 0; i < 4; i++) u_cfg_host_model.wr(8'(16 + 4 * i), '1, 4'hF);
        `CHK(wide_mode, 1'b0)
        chk_rd(8'h10, 32'hFFFE_0000);
        chk_rd(8'h14, 32'hFFFF_0000);
        chk_rd(8'h18, 32'hFFFF_FFF9);
        chk_rd(8'h1C, 32'h0000_0000);
        chk_rd(8'h28, 32'h0000_0022);
        `CHK(reg_base, 64'h0000_0000_FFFE_0000)
        `CHK(flash_base, 64'h0000_0000_FFFF_0000)
        @(posedge clock) clock_run_option <= 1'b0;
        chk_rd(8'h28, 32'h0000_0000);
        @(posedge clock) extended_bus_mode <= 1'b1;
        @(negedge clock) `CHK(wide_mode, 1'b1)
    endtask : t_narrow_map
    task automatic t_boot_rom;
        for (int f = 0; f < 4; f++) begin
            @(posedge clock) flash_size <= 2'(f);
            u_cfg_host_model.wr(8'h30, '1, 4'hF);
            chk_rd(8'h30, rm[f]);
            `CHK(rom_base, rm[f] & 32'hFFFF_FFFE)
        end
        `CHK(rom_enable, 1'b1)
        u_cfg_host_model.wr(8'h30, 32'h0000_0000, 4'hE);
        chk_rd(8'h30, 32'h0000_0001);
        u_cfg_host_model.wr(8'h30, 32'h0000_07FE, 4'hF);
        chk_rd(8'h30, 32'h0000_0000);
        `CHK(rom_enable, 1'b0)
        u_cfg_host_model.wr(8'h3C, '1, 4'hF);
        chk_rd(8'h3C, 32'h0000_0000);
    endtask : t_boot_rom
    task automatic t_mid_reset;
        u_cfg_host_model.wr(8'h30, 32'h0000_0001, 4'h1);
        @(negedge clock) `CHK(rom_enable, 1'b1)
        @(posedge clock) reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock) `CHK(rom_enable, 1'b0)
        `CHK(io_base, 32'h0000_0000)
        chk_rd(8'h30, 32'h0000_0000);
        chk_rd(8'h10, 32'h0000_0004);
        chk_rd(8'h20, 32'h0000_0001);
    endtask : t_mid_reset
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        t_wide_sizing();
        t_narrow_map();
        t_boot_rom();
        t_mid_reset();
        report_and_stop();
    end
endmodule : pci_bar_rom_cis_config_bench
